// ---- common/reload_timer_pkg.sv ----
// Constants for the 8-bit reload timer with fine rate adjust
package reload_timer_pkg;
   localparam int          ADDR_W          = 20;
   localparam int          DATA_W          = 32;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_RELOAD      = 16'h4202;
   localparam logic [15:0] IDX_COUNTER     = 16'h4204;
   localparam logic [15:0] IDX_CONTROL     = 16'h4206;
   localparam logic [15:0] IDX_INT_STATUS  = 16'h4208;
   localparam logic [15:0] IDX_INT_MASK    = 16'h420a;
   // Control, status and mask field positions
   localparam int          RUN_BIT         = 0;
   localparam int          PRESET_BIT      = 1;
   localparam int          MODE_BIT        = 4;
   localparam int          FINE_LSB        = 8;
   localparam int          FINE_MSB        = 11;
   localparam int          UF_INT_BIT      = 0;
   // Reset values, response codes and period length
   localparam logic [7:0]  COUNTER_RESET   = 8'hff;
   localparam logic [7:0]  RELOAD_RESET    = 8'h00;
   localparam logic [3:0]  FINE_RESET      = 4'h0;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_DECERR     = 2'b11;
   localparam int          PERIOD_LEN      = 16;
   // Delay masks; bit k-1 set means underflow k of the period is delayed
   localparam logic [15:0] FINE_MASK [16] = '{
      16'h0000, 16'h8000, 16'h8080, 16'h8880,
      16'h8888, 16'ha888, 16'ha8a8, 16'haaa8,
      16'haaaa, 16'heaaa, 16'heaea, 16'heaee,
      16'heeee, 16'hfeee, 16'hfefe, 16'hfffe};
   typedef enum logic {MODE_REPEAT, MODE_ONE_SHOT} count_mode_t;
endpackage

// ---- common/fine_if.sv ----
// Links the counter core with the fine pattern and output clock blocks
`timescale 1ns/100ps
`default_nettype none
interface fine_if;
   logic [3:0] fine_adjust_pattern;   // Delays per 16-underflow period
   logic       underflow;             // Corrected underflow pulse
   logic       delay_req;             // Current underflow must be delayed
   modport core (output fine_adjust_pattern, output underflow, input delay_req);
   modport pattern (input fine_adjust_pattern, input underflow, output delay_req);
   modport clk_out (input underflow);
endinterface
`default_nettype wire

// ---- src/fine_delay_pattern.sv ----
// Tracks underflow position in the 16-period and flags delayed ones
`timescale 1ns/100ps
`default_nettype none
module fine_delay_pattern (
   input  wire logic aclk,      // Clock
   input  wire logic aresetn,   // Sync reset, active low
   input  wire logic ce,        // Clock enable
   fine_if.pattern   fin        // Link to counter core
);
   import reload_timer_pkg::*;
   logic [3:0]  index_q;
   logic [15:0] mask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         index_q <= 4'h0;
      end else if (ce && fin.underflow) begin
         index_q <= index_q + 4'h1;
      end
   end

   assign mask          = FINE_MASK[fin.fine_adjust_pattern];
   assign fin.delay_req = mask[index_q];
endmodule
`default_nettype wire

// ---- src/toggle_clock_out.sv ----
// Derived output clock, toggling on each corrected underflow
`timescale 1ns/100ps
`default_nettype none
module toggle_clock_out (
   input  wire logic aclk,       // Clock
   input  wire logic aresetn,    // Sync reset, active low
   input  wire logic ce,         // Clock enable
   fine_if.clk_out   fin,        // Underflow source
   output logic      clk_out     // Derived clock
);
   logic pend_q;

   // Two cycles behind the underflow, so the edge trails underflow_out by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q  <= 1'b0;
         clk_out <= 1'b0;
      end else if (ce) begin
         pend_q <= fin.underflow;
         if (pend_q) begin
            clk_out <= ~clk_out;
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/reload_timer.sv ----
// 8-bit reload timer with fine rate adjust and AXI4-Lite registers
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module reload_timer (
   input  wire logic                             aclk,          // Clock, 100 MHz
   input  wire logic                             aresetn,       // Sync reset, active low
   input  wire logic                             ce,            // Clock enable, freezes all
   input  wire logic                             count_tick,    // Prescaler count clock pulse
   input  wire logic [reload_timer_pkg::ADDR_W-1:0] awaddr,     // Write address
   input  wire logic                             awvalid,       // Write address valid
   output logic                                  awready,       // Write address ready
   input  wire logic [reload_timer_pkg::DATA_W-1:0] wdata,      // Write data
   input  wire logic [3:0]                       wstrb,         // Write byte strobes
   input  wire logic                             wvalid,        // Write data valid
   output logic                                  wready,        // Write data ready
   output logic [1:0]                            bresp,         // Write response
   output logic                                  bvalid,        // Write response valid
   input  wire logic                             bready,        // Write response ready
   input  wire logic [reload_timer_pkg::ADDR_W-1:0] araddr,     // Read address
   input  wire logic                             arvalid,       // Read address valid
   output logic                                  arready,       // Read address ready
   output logic [reload_timer_pkg::DATA_W-1:0]   rdata,         // Read data
   output logic [1:0]                            rresp,         // Read response
   output logic                                  rvalid,        // Read data valid
   input  wire logic                             rready,        // Read data ready
   output logic                                  underflow_out, // Corrected underflow pulse
   output logic                                  clk_out,       // Derived output clock
   output logic                                  irq            // Level interrupt
);
   import reload_timer_pkg::*;

   fine_if fin ();

   logic [7:0]                count_field_q;
   logic [7:0]                reload_value_q;
   logic [3:0]                fine_q;
   count_mode_t               mode_q;
   logic                      run_q;
   logic                      stall_q;
   logic                      status_q;
   logic                      mask_q;
   logic                      at_zero;
   logic [ADDR_W-1:0]         aw_addr_q;
   logic [DATA_W-1:0]         w_data_q;
   logic [3:0]                w_strb_q;
   logic                      aw_held_q;
   logic                      w_held_q;
   logic                      do_write;
   logic                      do_read;
   logic                      wr_ctl;
   logic                      wr_rld;
   logic                      wr_mask;
   logic                      rd_status;
   logic                      preset;
   logic                      uf_now;
   logic [DATA_W-1:0]         rd_data_d;
   logic [1:0]                rd_resp_d;
   logic [1:0]                wr_resp_d;
   logic [DATA_W-1:0]         counter_word;
   logic [DATA_W-1:0]         control_word;
   logic [DATA_W-1:0]         reload_word;
   logic [DATA_W-1:0]         status_word;
   logic [DATA_W-1:0]         mask_word;

   // Bus write path: address and data may arrive in either order
   assign do_write = aw_held_q && w_held_q && !bvalid;
   assign do_read  = arvalid && arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= awaddr;
            awready   <= 1'b0;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end else if (!aw_held_q && !bvalid) begin
            awready   <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready   <= 1'b1;
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= 4'h0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_held_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready   <= 1'b0;
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end else if (!w_held_q && !bvalid) begin
            wready   <= 1'b1;
         end
      end
   end

   // Write decode
   always_comb begin
      wr_ctl    = 1'b0;
      wr_rld    = 1'b0;
      wr_mask   = 1'b0;
      wr_resp_d = RESP_OKAY;
      if (aw_addr_q == {2'b00, IDX_CONTROL, 2'b00}) begin
         wr_ctl = do_write;
      end else if (aw_addr_q == {2'b00, IDX_RELOAD, 2'b00}) begin
         wr_rld = do_write;
      end else if (aw_addr_q == {2'b00, IDX_INT_MASK, 2'b00}) begin
         wr_mask = do_write;
      end else if (aw_addr_q == {2'b00, IDX_COUNTER, 2'b00}) begin
         wr_resp_d = RESP_OKAY;
      end else if (aw_addr_q == {2'b00, IDX_INT_STATUS, 2'b00}) begin
         wr_resp_d = RESP_OKAY;
      end else begin
         wr_resp_d = RESP_DECERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_resp_d;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Preset takes effect only for a 1 in the low lane
   assign preset = wr_ctl && w_strb_q[0] && w_data_q[PRESET_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fine_q <= FINE_RESET;
         mode_q <= MODE_REPEAT;
      end else if (ce && wr_ctl) begin
         if (w_strb_q[1]) begin
            fine_q <= w_data_q[FINE_MSB:FINE_LSB];
         end
         if (w_strb_q[0]) begin
            // Changing mode mid-count is allowed but software should not
            mode_q <= count_mode_t'(w_data_q[MODE_BIT]);
         end
      end
   end

   // Reload lives in the low lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_value_q <= RELOAD_RESET;
      end else if (ce && wr_rld && w_strb_q[0]) begin
         reload_value_q <= w_data_q[7:0];
      end
   end

   // Mask only gates the pin; the flag sets regardless
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= 1'b0;
      end else if (ce && wr_mask && w_strb_q[0]) begin
         mask_q <= w_data_q[UF_INT_BIT];
      end
   end

   // Underflow happens at zero on a tick; a delayed one holds one more tick
   assign at_zero = run_q && count_tick && (count_field_q == 8'h00);
   assign uf_now  = at_zero && (stall_q || !fin.delay_req);

   // A software write of run beats the one-shot self stop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 1'b0;
      end else if (ce) begin
         if (wr_ctl && w_strb_q[0]) begin
            run_q <= w_data_q[RUN_BIT];
         end else if (uf_now && mode_q == MODE_ONE_SHOT) begin
            run_q <= 1'b0;
         end
      end
   end

   // Stall marks a zero count whose underflow the pattern pushed back
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stall_q <= 1'b0;
      end else if (ce) begin
         if (preset || uf_now) begin
            stall_q <= 1'b0;
         end else if (at_zero) begin
            stall_q <= 1'b1;
         end
      end
   end

   // Ticks while stopped leave the count untouched
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_field_q <= COUNTER_RESET;
      end else if (ce) begin
         if (preset || uf_now) begin
            count_field_q <= reload_value_q;
         end else if (run_q && count_tick && count_field_q != 8'h00) begin
            count_field_q <= count_field_q - 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         underflow_out <= 1'b0;
      end else if (ce) begin
         underflow_out <= uf_now;
      end
   end

   // Slot advances on the underflow edge itself; a registered copy lags back-to-back ticks
   assign fin.fine_adjust_pattern = fine_q;
   assign fin.underflow           = uf_now;

   fine_delay_pattern u_pattern (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .fin     (fin)
   );

   toggle_clock_out u_clk_out (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .fin     (fin),
      .clk_out (clk_out)
   );

   // Register images, reserved bits held at zero
   always_comb begin
      counter_word                    = '0;
      control_word                    = '0;
      reload_word                     = '0;
      status_word                     = '0;
      mask_word                       = '0;
      counter_word[7:0]               = count_field_q;
      control_word[FINE_MSB:FINE_LSB] = fine_q;
      control_word[MODE_BIT]          = mode_q;
      control_word[PRESET_BIT]        = 1'b0;
      control_word[RUN_BIT]           = run_q;
      reload_word[7:0]                = reload_value_q;
      status_word[UF_INT_BIT]         = status_q;
      mask_word[UF_INT_BIT]           = mask_q;
   end

   // Read decode
   always_comb begin
      rd_data_d = '0;
      rd_resp_d = RESP_OKAY;
      rd_status = 1'b0;
      if (araddr == {2'b00, IDX_COUNTER, 2'b00}) begin
         rd_data_d = counter_word;
      end else if (araddr == {2'b00, IDX_CONTROL, 2'b00}) begin
         rd_data_d = control_word;
      end else if (araddr == {2'b00, IDX_RELOAD, 2'b00}) begin
         rd_data_d = reload_word;
      end else if (araddr == {2'b00, IDX_INT_STATUS, 2'b00}) begin
         rd_data_d = status_word;
         rd_status = do_read;
      end else if (araddr == {2'b00, IDX_INT_MASK, 2'b00}) begin
         rd_data_d = mask_word;
      end else begin
         rd_resp_d = RESP_DECERR;
      end
   end

   // Read data is captured at the handshake and stands until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (ce) begin
         if (do_read) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data_d;
            rresp   <= rd_resp_d;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // Sticky flag; a new underflow beats a clearing read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= 1'b0;
      end else if (ce) begin
         if (uf_now) begin
            status_q <= 1'b1;
         end else if (rd_status) begin
            status_q <= 1'b0;
         end
      end
   end

   // One cycle behind the flag, traded for a glitch-free pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= status_q && mask_q;
      end
   end
endmodule
`default_nettype wire

// ---- verification/reload_timer_props.sv ----
// Port-level timing checks for the reload timer
`timescale 1ns/100ps
`default_nettype none
module reload_timer_props
   import reload_timer_pkg::*;
(
   input wire logic              aclk,          // Clock
   input wire logic              aresetn,       // Sync reset, active low
   input wire logic              awvalid,       // Write address valid
   input wire logic              awready,       // Write address ready
   input wire logic              wvalid,        // Write data valid
   input wire logic              wready,        // Write data ready
   input wire logic [1:0]        bresp,         // Write response
   input wire logic              bvalid,        // Write response valid
   input wire logic              bready,        // Write response ready
   input wire logic [ADDR_W-1:0] araddr,        // Read address
   input wire logic              arvalid,       // Read address valid
   input wire logic              arready,       // Read address ready
   input wire logic [DATA_W-1:0] rdata,         // Read data
   input wire logic [1:0]        rresp,         // Read response
   input wire logic              rvalid,        // Read data valid
   input wire logic              rready,        // Read data ready
   input wire logic              underflow_out, // Corrected underflow pulse
   input wire logic              clk_out,       // Derived clock
   input wire logic              irq            // Level interrupt
);
   localparam logic [19:0] A_CNT = {2'b00, IDX_COUNTER, 2'b00};
   localparam logic [19:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_clk_follows_uf: assert property ((clk_out != $past(clk_out)) == $past(underflow_out))
      else $error("clk_out toggle does not match underflow_out");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before bready");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped before rready");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write answer late");
   a_write_blocked: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   a_read_blocked: assert property (rvalid |-> !arready)
      else $error("read accepted while data pending");
   a_counter_rsvd: assert property (arvalid && arready && araddr == A_CNT |=> rdata[31:8] == 24'h0)
      else $error("counter upper bits not zero");
   a_control_rsvd: assert property (arvalid && arready && araddr == A_CTL |=> (rdata & 32'hffff_f0ee) == 32'h0)
      else $error("control reserved or preset bit not zero");
   a_irq_cause: assert property ($rose(irq) |-> $past(underflow_out) || bvalid || $past(bvalid))
      else $error("irq rose without underflow or mask write");
   c_underflow: cover property (underflow_out);
   c_irq: cover property ($rose(irq));
   c_decerr: cover property (bvalid && bresp == RESP_DECERR);
endmodule
bind reload_timer reload_timer_props u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
   .rready, .underflow_out, .clk_out, .irq);
`default_nettype wire

// ---- verification/test_reload_timer.sv ----
// Self-checking bench for the reload timer against an integer model
`timescale 1ns/100ps
`default_nettype none
module test_reload_timer;
   import reload_timer_pkg::*;
   logic        aclk = 0, aresetn = 0, ce = 1, count_tick = 0;
   logic [19:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, underflow_out, clk_out, irq;
   logic [1:0]  bresp, rresp, r;
   int          num_errors, compares, cnt = 255, rld, fine, mode, run, upos, held, sts, msk;
   int          uf_exp, uf_seen, goal, seed;
   localparam logic [19:0] A_RLD = {2'b00, IDX_RELOAD, 2'b00};
   localparam logic [19:0] A_CNT = {2'b00, IDX_COUNTER, 2'b00};
   localparam logic [19:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
   localparam logic [19:0] A_STS = {2'b00, IDX_INT_STATUS, 2'b00};
   localparam logic [19:0] A_MSK = {2'b00, IDX_INT_MASK, 2'b00};
   // Delayed underflows per fine value, bit k-1 for underflow k
   localparam logic [15:0] PAT [16] = '{16'h0000, 16'h8000, 16'h8080, 16'h8880, 16'h8888,
      16'ha888, 16'ha8a8, 16'haaa8, 16'haaaa, 16'heaaa, 16'heaea, 16'heaee, 16'heeee,
      16'hfeee, 16'hfefe, 16'hfffe};
   reload_timer DUT (.aclk, .aresetn, .ce, .count_tick, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .underflow_out, .clk_out, .irq);
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (underflow_out === 1'b1) uf_seen <= uf_seen + 1;
   end
   task automatic test_done;
      if (num_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", {30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [19:0] a, output logic [31:0] v, output logic [1:0] rr);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [19:0] a, input logic [31:0] e);
      rd(a, d, r);
      check("rdata", d, e);
      check("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   task automatic ctl(input int rn, input int m, input int f, input int p);
      wr(A_CTL, 32'(f << 8 | m << 4 | p << 1 | rn), RESP_OKAY);
      run = rn;
      mode = m;
      fine = f;
      if (p != 0) begin
         cnt = rld;
         held = 0;
      end
   endtask
   // Model steps one count clock, then compares irq and counter
   task automatic tick;
      @(posedge aclk);
      count_tick <= 1'b1;
      @(posedge aclk);
      count_tick <= 1'b0;
      if (run != 0) begin
         if (cnt != 0) cnt--;
         else if (PAT[fine][upos] && held == 0) held = 1;
         else begin
            cnt = rld;
            upos = (upos + 1) % 16;
            held = 0;
            sts = 1;
            uf_exp++;
            if (mode != 0) run = 0;
         end
      end
      repeat (3) @(posedge aclk);
      check("irq", {31'h0, irq}, sts & msk);
      rchk(A_CNT, cnt);
   endtask
   initial begin
      repeat (60000) @(posedge aclk);
      num_errors++;
      test_done();
   end
   initial begin
      seed = $urandom(70815);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(A_CNT, 32'h0000_00ff);
      rchk(A_CTL, 32'h0);
      rchk(A_RLD, 32'h0);
      wr(A_CNT, 32'hffff_ff12, RESP_OKAY);
      rchk(A_CNT, 32'h0000_00ff);
      rd(A_CTL + 20'h18, d, r);
      check("rresp", {30'h0, r}, {30'h0, RESP_DECERR});
      check("rdata", d, 32'h0);
      wr(A_CTL + 20'h18, 32'h1, RESP_DECERR);
      msk = 1;
      wr(A_MSK, 32'h1, RESP_OKAY);
      rld = 1 + $urandom % 3;
      wr(A_RLD, rld, RESP_OKAY);
      ctl(0, 0, 0, 0);
      tick();
      rchk(A_CNT, 32'h0000_00ff);
      ctl(0, 0, 0, 1);
      rchk(A_CTL, 32'h0);
      ctl(1, 0, 0, 0);
      @(posedge aclk);
      ce <= 1'b0;
      count_tick <= 1'b1;
      @(posedge aclk);
      ce <= 1'b1;
      count_tick <= 1'b0;
      rchk(A_CNT, cnt);
      repeat (3 * (rld + 1)) tick();
      rchk(A_STS, sts);
      sts = 0;
      msk = 0;
      wr(A_MSK, 32'h0, RESP_OKAY);
      repeat (rld + 1) tick();
      rchk(A_STS, sts);
      sts = 0;
      for (int f = 0; f < 16; f++) begin
         ctl(0, 0, f, 0);
         rld = $urandom % 3;
         wr(A_RLD, rld, RESP_OKAY);
         ctl(1, 0, f, 0);
         rchk(A_CTL, 32'(f << 8 | 1));
         goal = uf_exp + 16;
         while (uf_exp < goal) tick();
      end
      ctl(0, 1, 0, 1);
      ctl(1, 1, 0, 0);
      repeat (rld + 3) tick();
      rchk(A_CTL, 32'h10);
      repeat (10) @(posedge aclk);
      check("underflows", uf_seen, uf_exp);
      test_done();
   end
endmodule
`default_nettype wire
